// >>> core/lcsf_pkg.sv
package lcsf_pkg;

  localparam int NUM_CH = 5;

  // register offsets on the register port
  localparam logic [7:0] ADDR_CONFIG_ONE = 8'h40;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
  localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h7A;

  // channel order: 0 core rail, 1 supply, 2 remote one, 3 local, 4 remote two
  localparam logic [NUM_CH-1:0][7:0] LOW_ADDR = {8'h52, 8'h50, 8'h4E, 8'h48, 8'h46};
  localparam logic [NUM_CH-1:0][7:0] HIGH_ADDR = {8'h53, 8'h51, 8'h4F, 8'h49, 8'h47};
  localparam logic [NUM_CH-1:0][7:0] LOW_RESET = {8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
  localparam logic [NUM_CH-1:0][7:0] HIGH_RESET = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [NUM_CH-1:0][2:0] STATUS_ONE_BIT = {3'h6, 3'h5, 3'h4, 3'h2, 3'h1};

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] TIMER_LIMIT_RESET = 8'h00;

  // field positions
  localparam int BIT_SUMMARY = 7;
  localparam int BIT_R2_LATCH = 0;
  localparam int BIT_OVERTEMP = 1;
  localparam int BIT_FAN_ONE = 2;
  localparam int BIT_FAN_FOUR = 5;
  localparam int BIT_DIODE_ONE = 6;
  localparam int BIT_DIODE_TWO = 7;
  localparam int BIT_CFG_LOCK = 1;
  localparam int BIT_CFG_LATCH_RESET = 7;

  // overtemp timer: one tick of the accumulator
  localparam int CLK_PERIOD_NS = 20;
  localparam int TIMER_TICK_US = 1000;
  localparam int TIMER_TICK_CYCLES = (TIMER_TICK_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LCSF_PIN_FAN_FOUR = 2'b00,
    LCSF_PIN_GPIO_OUT = 2'b01,
    LCSF_PIN_TIMER_IN = 2'b10
  } lcsf_pin_mode_t;

endpackage : lcsf_pkg

// >>> core/lcsf_limit_cmp.sv
`timescale 1ns/1ns
`default_nettype none

module lcsf_limit_cmp #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] reading,
  input wire logic [WIDTH-1:0] low_limit,
  input wire logic [WIDTH-1:0] high_limit,
  output logic violation
);

  always_comb begin
    // high side strictly above, low side at or below
    violation = (reading > high_limit) || (reading <= low_limit);
  end

endmodule : lcsf_limit_cmp

`default_nettype wire

// >>> core/lcsf_overtemp_timer.sv
`timescale 1ns/1ns
`default_nettype none

module lcsf_overtemp_timer #(
  parameter int TICK_CYCLES = lcsf_pkg::TIMER_TICK_CYCLES,
  parameter int ACC_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic asserted,
  input wire logic clear,
  input wire logic [ACC_WIDTH-1:0] limit,
  output logic exceeded
);

  logic [31:0] prescale;
  logic [31:0] next_prescale;
  logic [ACC_WIDTH-1:0] acc;
  logic [ACC_WIDTH-1:0] next_acc;

  always_comb begin
    next_prescale = prescale;
    next_acc = acc;
    if (clear || !enable) begin
      next_prescale = 32'h0;
      next_acc = '0;
    end else if (asserted) begin
      if (prescale == 32'(TICK_CYCLES - 1)) begin
        next_prescale = 32'h0;
        // saturate so a long assertion never wraps back under the limit
        if (acc != '1) begin
          next_acc = acc + 1'b1;
        end
      end else begin
        next_prescale = prescale + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale <= 32'h0;
      acc <= '0;
    end else begin
      prescale <= next_prescale;
      acc <= next_acc;
    end
  end

  assign exceeded = enable && (acc > limit);

endmodule : lcsf_overtemp_timer

`default_nettype wire

// >>> core/lcsf_status.sv
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - status one bits 1,2,4,5,6 flag core, supply, remote one, local, remote two.
// - reading status clears a voltage or temperature flag only if violation gone.
// - status one bit 7 always ORs every status two flag.
// - status two bit 1 sets on overtemp; read clears only below threshold less hysteresis.
// - status two bits 2,3,4 flag slow or stalled fans one to three.
// - fan flags suppressed while their drive is off; fan four follows drive three.
// - default pin mode: status two bit 5 flags slow or stalled fan four.
// - gpio pin mode: writing status two bit 5 sets the pin level.
// - timer pin mode: bit 5 sets when accumulated assertion time exceeds timer limit.
// - status two bits 6 and 7 flag open or short on diodes one and two.
// - status two bit 0 reserved on base variant, latched remote two overtemp otherwise.
// - high violation only when reading strictly above high limit.
// - low violation when reading equal to or below low limit.
// - temperature limits reset to 0x01 low, 0xFF high; a reading at or below 0x01 flags, no reading can pass 0xFF.
// - limit registers stay writable regardless of configuration lock.
// - both status registers read zero after reset.
// - latching variant: writing config one bit 7 clears latched conditions.
module lcsf_status #(
  parameter bit LATCHING = 1'b0,
  parameter int TIMER_TICK_CYCLES = lcsf_pkg::TIMER_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [7:0] core_rail_reading,
  input wire logic [7:0] supply_reading,
  input wire logic [7:0] remote_one_temp,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote_two_temp,
  input wire logic overtemp_exceeded,
  input wire logic overtemp_below_hyst,
  input wire logic [3:0] fan_slow,
  input wire logic drive_out_one,
  input wire logic drive_out_two,
  input wire logic drive_out_three,
  input wire logic diode_one_open_short,
  input wire logic diode_two_open_short,
  input wire logic remote_two_limit_event,
  input wire logic [1:0] shared_pin_mode,
  input wire logic overtemp_pin_n,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic config_locked
);

  localparam int N = lcsf_pkg::NUM_CH;

  logic [N-1:0][7:0] low_limit;
  logic [N-1:0][7:0] next_low_limit;
  logic [N-1:0][7:0] high_limit;
  logic [N-1:0][7:0] next_high_limit;
  logic [7:0] timer_limit;
  logic [7:0] next_timer_limit;
  logic [7:0] status_one;
  logic [7:0] next_status_one;
  logic [7:0] status_two;
  logic [7:0] next_status_two;
  logic [N-1:0] viol_held;
  logic [N-1:0] next_viol_held;
  logic [7:0] next_reg_rdata;
  logic next_shared_pin_out;
  logic next_shared_pin_oe;
  logic next_config_locked;

  logic [N-1:0][7:0] reading;
  logic [N-1:0] violation;
  lcsf_pkg::lcsf_pin_mode_t pin_mode;
  logic rd_one;
  logic rd_two;
  logic wr_two;
  logic wr_config;
  logic latch_reset;
  logic timer_exceeded;
  logic timer_clear;
  logic [2:0] drive_on;
  logic [2:0] fan_cond;
  logic fan_four_cond;
  logic summary;

  assign reading = {remote_two_temp, local_temp, remote_one_temp, supply_reading,
                    core_rail_reading};
  assign drive_on = {drive_out_three, drive_out_two, drive_out_one};

  // an unused code on the mode pins falls back to the fan four default
  always_comb begin
    unique case (shared_pin_mode)
      2'b01: pin_mode = lcsf_pkg::LCSF_PIN_GPIO_OUT;
      2'b10: pin_mode = lcsf_pkg::LCSF_PIN_TIMER_IN;
      default: pin_mode = lcsf_pkg::LCSF_PIN_FAN_FOUR;
    endcase
  end

  assign rd_one = reg_rd && (reg_addr == lcsf_pkg::ADDR_STATUS_ONE);
  assign rd_two = reg_rd && (reg_addr == lcsf_pkg::ADDR_STATUS_TWO);
  assign wr_two = reg_wr && (reg_addr == lcsf_pkg::ADDR_STATUS_TWO);
  assign wr_config = reg_wr && (reg_addr == lcsf_pkg::ADDR_CONFIG_ONE);
  assign latch_reset = LATCHING && wr_config && reg_wdata[lcsf_pkg::BIT_CFG_LATCH_RESET];

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_cmp
      lcsf_limit_cmp #(
        .WIDTH(8)
      ) u_cmp (
        .reading(reading[gi]),
        .low_limit(low_limit[gi]),
        .high_limit(high_limit[gi]),
        .violation(violation[gi])
      );
    end
    for (gi = 0; gi < 3; gi++) begin : g_fan
      assign fan_cond[gi] = fan_slow[gi] && drive_on[gi];
    end
  endgenerate

  assign fan_four_cond = fan_slow[3] && drive_out_three;

  // a status two read restarts the accumulator only while the timer limit is not exceeded
  assign timer_clear = rd_two && !timer_exceeded;

  lcsf_overtemp_timer #(
    .TICK_CYCLES(TIMER_TICK_CYCLES),
    .ACC_WIDTH(8)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .enable(pin_mode == lcsf_pkg::LCSF_PIN_TIMER_IN),
    .asserted(!overtemp_pin_n),
    .clear(timer_clear),
    .limit(timer_limit),
    .exceeded(timer_exceeded)
  );

  // summary taken from the next flags so it never lags status two
  assign summary = |next_status_two;

  always_comb begin
    next_low_limit = low_limit;
    next_high_limit = high_limit;
    next_timer_limit = timer_limit;
    next_status_one = status_one;
    next_status_two = status_two;
    next_viol_held = viol_held;
    next_config_locked = config_locked;
    next_reg_rdata = reg_rdata;
    next_shared_pin_out = shared_pin_out;
    next_shared_pin_oe = (pin_mode == lcsf_pkg::LCSF_PIN_GPIO_OUT);

    // limit writes never consult the lock bit
    for (int i = 0; i < N; i++) begin
      if (reg_wr && (reg_addr == lcsf_pkg::LOW_ADDR[i])) begin
        next_low_limit[i] = reg_wdata;
      end
      if (reg_wr && (reg_addr == lcsf_pkg::HIGH_ADDR[i])) begin
        next_high_limit[i] = reg_wdata;
      end
    end
    if (reg_wr && (reg_addr == lcsf_pkg::ADDR_TIMER_LIMIT)) begin
      next_timer_limit = reg_wdata;
    end
    // lock is write once: it can be set but never cleared before reset
    if (wr_config && reg_wdata[lcsf_pkg::BIT_CFG_LOCK]) begin
      next_config_locked = 1'b1;
    end

    // readback value is taken from the flags before this edge's clear
    if (rd_one) begin
      next_reg_rdata = status_one;
      next_reg_rdata[lcsf_pkg::BIT_SUMMARY] = |status_two;
    end else if (rd_two) begin
      next_reg_rdata = status_two;
    end

    // limit registers are plain read/write storage, so the host sees what it wrote
    for (int i = 0; i < N; i++) begin
      if (reg_rd && (reg_addr == lcsf_pkg::LOW_ADDR[i])) begin
        next_reg_rdata = low_limit[i];
      end
      if (reg_rd && (reg_addr == lcsf_pkg::HIGH_ADDR[i])) begin
        next_reg_rdata = high_limit[i];
      end
    end
    if (reg_rd && (reg_addr == lcsf_pkg::ADDR_TIMER_LIMIT)) begin
      next_reg_rdata = timer_limit;
    end

    // status one: clear first, then set, so a fresh violation wins
    if (sample_valid) begin
      next_viol_held = violation;
    end
    for (int i = 0; i < N; i++) begin
      if (rd_one && !viol_held[i]) begin
        next_status_one[lcsf_pkg::STATUS_ONE_BIT[i]] = 1'b0;
      end
      if (sample_valid && violation[i]) begin
        next_status_one[lcsf_pkg::STATUS_ONE_BIT[i]] = 1'b1;
      end
    end

    // status two
    if (rd_two && overtemp_below_hyst) begin
      next_status_two[lcsf_pkg::BIT_OVERTEMP] = 1'b0;
    end
    if (overtemp_exceeded) begin
      next_status_two[lcsf_pkg::BIT_OVERTEMP] = 1'b1;
    end
    for (int i = 0; i < 3; i++) begin
      if (rd_two && !fan_cond[i]) begin
        next_status_two[lcsf_pkg::BIT_FAN_ONE + i] = 1'b0;
      end
      if (fan_cond[i]) begin
        next_status_two[lcsf_pkg::BIT_FAN_ONE + i] = 1'b1;
      end
    end
    unique case (pin_mode)
      lcsf_pkg::LCSF_PIN_GPIO_OUT: begin
        if (wr_two) begin
          next_status_two[lcsf_pkg::BIT_FAN_FOUR] = reg_wdata[lcsf_pkg::BIT_FAN_FOUR];
          next_shared_pin_out = reg_wdata[lcsf_pkg::BIT_FAN_FOUR];
        end
      end
      lcsf_pkg::LCSF_PIN_TIMER_IN: begin
        if (rd_two && !timer_exceeded) begin
          next_status_two[lcsf_pkg::BIT_FAN_FOUR] = 1'b0;
        end
        if (timer_exceeded) begin
          next_status_two[lcsf_pkg::BIT_FAN_FOUR] = 1'b1;
        end
      end
      lcsf_pkg::LCSF_PIN_FAN_FOUR: begin
        if (rd_two && !fan_four_cond) begin
          next_status_two[lcsf_pkg::BIT_FAN_FOUR] = 1'b0;
        end
        if (fan_four_cond) begin
          next_status_two[lcsf_pkg::BIT_FAN_FOUR] = 1'b1;
        end
      end
    endcase
    if (rd_two && !diode_one_open_short) begin
      next_status_two[lcsf_pkg::BIT_DIODE_ONE] = 1'b0;
    end
    if (diode_one_open_short) begin
      next_status_two[lcsf_pkg::BIT_DIODE_ONE] = 1'b1;
    end
    if (rd_two && !diode_two_open_short) begin
      next_status_two[lcsf_pkg::BIT_DIODE_TWO] = 1'b0;
    end
    if (diode_two_open_short) begin
      next_status_two[lcsf_pkg::BIT_DIODE_TWO] = 1'b1;
    end
    // latch bit ignores reads; only the latch reset write takes it down
    if (LATCHING) begin
      if (latch_reset) begin
        next_status_two[lcsf_pkg::BIT_R2_LATCH] = 1'b0;
      end
      if (remote_two_limit_event) begin
        next_status_two[lcsf_pkg::BIT_R2_LATCH] = 1'b1;
      end
    end else begin
      next_status_two[lcsf_pkg::BIT_R2_LATCH] = 1'b0;
    end

    // stored copy of the summary bit, kept for consistency with status two
    next_status_one[lcsf_pkg::BIT_SUMMARY] = summary;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_limit <= lcsf_pkg::LOW_RESET;
      high_limit <= lcsf_pkg::HIGH_RESET;
      timer_limit <= lcsf_pkg::TIMER_LIMIT_RESET;
      status_one <= lcsf_pkg::STATUS_RESET;
      status_two <= lcsf_pkg::STATUS_RESET;
      viol_held <= '0;
      config_locked <= 1'b0;
      reg_rdata <= 8'h00;
      shared_pin_out <= 1'b0;
      shared_pin_oe <= 1'b0;
    end else begin
      low_limit <= next_low_limit;
      high_limit <= next_high_limit;
      timer_limit <= next_timer_limit;
      status_one <= next_status_one;
      status_two <= next_status_two;
      viol_held <= next_viol_held;
      config_locked <= next_config_locked;
      reg_rdata <= next_reg_rdata;
      shared_pin_out <= next_shared_pin_out;
      shared_pin_oe <= next_shared_pin_oe;
    end
  end

endmodule : lcsf_status

`default_nettype wire

// >>> sim/lcsf_status_properties.sv
`timescale 1ns/1ns
`default_nettype none
module lcsf_status_chk #(
  parameter bit LATCHING = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] shared_pin_mode,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe,
  input wire logic config_locked
);
  logic wbit;
  assign wbit = reg_wdata[5];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_reset_values: assert property ($fell(rst) |->
    reg_rdata == 8'h00 && !config_locked && !shared_pin_oe && !shared_pin_out)
    else $error("outputs not cleared by reset");
  chk_pin_enable: assert property (!$past(rst) |->
    shared_pin_oe == ($past(shared_pin_mode) == 2'h1))
    else $error("pin enable does not follow gpio mode");
  chk_gpio_level: assert property (reg_wr && reg_addr == lcsf_pkg::ADDR_STATUS_TWO &&
    shared_pin_mode == 2'h1 |=> shared_pin_out == $past(wbit))
    else $error("gpio level not taken from write");
  chk_pin_hold: assert property (!(reg_wr && reg_addr == lcsf_pkg::ADDR_STATUS_TWO)
    |=> $stable(shared_pin_out))
    else $error("gpio level moved without write");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  chk_reserved_bits: assert property (reg_rd && reg_addr == lcsf_pkg::ADDR_STATUS_ONE
    |=> reg_rdata[0] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("unused status one bits set");
  chk_base_reserved: assert property (reg_rd && reg_addr == lcsf_pkg::ADDR_STATUS_TWO
    && !LATCHING |=> reg_rdata[0] == 1'b0)
    else $error("reserved status two bit set");
  chk_lock_set: assert property (reg_wr && reg_addr == lcsf_pkg::ADDR_CONFIG_ONE
    && reg_wdata[1] |=> config_locked)
    else $error("lock bit not set by write");
endmodule : lcsf_status_chk
bind lcsf_status lcsf_status_chk #(.LATCHING(LATCHING)) u_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .shared_pin_mode(shared_pin_mode), .shared_pin_out(shared_pin_out),
  .shared_pin_oe(shared_pin_oe), .config_locked(config_locked));
`default_nettype wire

// >>> sim/lcsf_host.sv
`timescale 1ns/1ns
`default_nettype none
module lcsf_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // called just after an edge; the idle cycle keeps strobes from being reassigned at once
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge clk);
    #2;
  endtask : xfer
endmodule : lcsf_host
`default_nettype wire

// >>> sim/limit_compare_status_flags_tb.sv
`timescale 1ns/1ns
`default_nettype none
module limit_compare_status_flags_tb;
  localparam logic [7:0] st_one = lcsf_pkg::ADDR_STATUS_ONE;
  localparam logic [7:0] st_two = lcsf_pkg::ADDR_STATUS_TWO;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, last, e, h;
  logic reg_wr, reg_rd, sample_valid, overtemp_exceeded, overtemp_below_hyst;
  logic drive_out_one, drive_out_two, drive_out_three, diode_one_open_short;
  logic diode_two_open_short, remote_two_limit_event, overtemp_pin_n;
  logic shared_pin_out, shared_pin_oe, config_locked;
  logic pend = 1'b0;
  logic pend_l = 1'b0;
  logic dual = 1'b0;
  logic [7:0] reg_rdata_l;
  logic [7:0] expq_l [$];
  logic [3:0] fan_slow;
  logic [1:0] shared_pin_mode;
  logic [7:0] rdg [5];
  logic [7:0] expq [$];
  int mismatches = 0;
  int tests_run = 0;
  int seed = 32'h0092;
  int i, k;
  always #10 clk = ~clk;
  lcsf_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  lcsf_status #(.LATCHING(1'b0), .TIMER_TICK_CYCLES(4)) u_dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .core_rail_reading(rdg[0]),
    .supply_reading(rdg[1]), .remote_one_temp(rdg[2]), .local_temp(rdg[3]),
    .remote_two_temp(rdg[4]), .overtemp_exceeded(overtemp_exceeded),
    .overtemp_below_hyst(overtemp_below_hyst), .fan_slow(fan_slow),
    .drive_out_one(drive_out_one), .drive_out_two(drive_out_two),
    .drive_out_three(drive_out_three), .diode_one_open_short(diode_one_open_short),
    .diode_two_open_short(diode_two_open_short),
    .remote_two_limit_event(remote_two_limit_event), .shared_pin_mode(shared_pin_mode),
    .overtemp_pin_n(overtemp_pin_n), .shared_pin_out(shared_pin_out),
    .shared_pin_oe(shared_pin_oe), .config_locked(config_locked));
  // latching variant shares every input; only its read data is compared
  lcsf_status #(.LATCHING(1'b1), .TIMER_TICK_CYCLES(4)) u_dut_latch (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata_l), .sample_valid(sample_valid), .core_rail_reading(rdg[0]),
    .supply_reading(rdg[1]), .remote_one_temp(rdg[2]), .local_temp(rdg[3]),
    .remote_two_temp(rdg[4]), .overtemp_exceeded(overtemp_exceeded),
    .overtemp_below_hyst(overtemp_below_hyst), .fan_slow(fan_slow),
    .drive_out_one(drive_out_one), .drive_out_two(drive_out_two),
    .drive_out_three(drive_out_three), .diode_one_open_short(diode_one_open_short),
    .diode_two_open_short(diode_two_open_short),
    .remote_two_limit_event(remote_two_limit_event), .shared_pin_mode(shared_pin_mode),
    .overtemp_pin_n(overtemp_pin_n), .shared_pin_out(), .shared_pin_oe(),
    .config_locked());
  task automatic cmp8(input string n, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : cmp8
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    expq.push_back(x);
    last = x;
    u_host.xfer(1'b0, a, 8'h00);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd2(input logic [7:0] a, input logic [7:0] x, input logic [7:0] xl);
    expq_l.push_back(xl);
    dual = 1'b1;
    rd(a, x);
    dual = 1'b0;
  endtask : rd2
  task automatic smp;
    sample_valid = 1'b1;
    @(posedge clk);
    #2;
    sample_valid = 1'b0;
    @(posedge clk);
    #2;
  endtask : smp
  task automatic conclude;
    if (expq.size() != 0 || expq_l.size() != 0) mismatches++;
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // read data is registered at the taking edge, so it is settled by the falling edge
  always @(posedge clk) pend <= reg_rd;
  always @(posedge clk) pend_l <= reg_rd && dual;
  always @(negedge clk) begin
    if (pend) cmp8("reg_rdata", expq.pop_front(), reg_rdata);
    if (pend_l) cmp8("reg_rdata_l", expq_l.pop_front(), reg_rdata_l);
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    sample_valid = 1'b0;
    for (i = 0; i < 5; i++) rdg[i] = 8'h00;
    {fan_slow, diode_two_open_short, diode_one_open_short, overtemp_exceeded} = 7'h00;
    {drive_out_one, drive_out_two, drive_out_three} = 3'h7;
    overtemp_below_hyst = 1'b1;
    remote_two_limit_event = 1'b0;
    shared_pin_mode = 2'h0;
    overtemp_pin_n = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    rst = 1'b0;
    rd(st_one, 8'h00);
    rd(st_two, 8'h00);
    for (i = 0; i < 5; i++) begin
      rd(lcsf_pkg::LOW_ADDR[i], lcsf_pkg::LOW_RESET[i]);
      rd(lcsf_pkg::HIGH_ADDR[i], lcsf_pkg::HIGH_RESET[i]);
    end
    rd(8'h00, last);
    wr(lcsf_pkg::ADDR_CONFIG_ONE, 8'h02);
    cmp8("config_locked", 8'h01, {7'h00, config_locked});
    h = 8'(($random(seed) & 32'h7F) + 32'h10);
    for (i = 0; i < 5; i++) wr(lcsf_pkg::HIGH_ADDR[i], h);
    rd(lcsf_pkg::HIGH_ADDR[4], h);
    // at the high limit, one past it, clear, at the low limit, clear
    for (k = 0; k < 5; k++) begin
      for (i = 0; i < 5; i++) begin
        case (k)
          0: rdg[i] = h;
          1: rdg[i] = h + 8'h01;
          3: rdg[i] = lcsf_pkg::LOW_RESET[i];
          default: rdg[i] = lcsf_pkg::LOW_RESET[i] + 8'h01;
        endcase
      end
      smp();
      rd(st_one, (k == 0) ? 8'h00 : 8'h76);
      rd(st_one, k[0] ? 8'h76 : 8'h00);
    end
    for (k = 0; k < 6; k++) begin
      {fan_slow, drive_out_three, drive_out_two, drive_out_one, diode_two_open_short,
        diode_one_open_short, overtemp_exceeded, remote_two_limit_event} = 11'($random(seed));
      overtemp_below_hyst = 1'b0;
      e = {diode_two_open_short, diode_one_open_short, fan_slow[3] & drive_out_three,
        fan_slow[2] & drive_out_three, fan_slow[1] & drive_out_two,
        fan_slow[0] & drive_out_one, overtemp_exceeded, 1'b0};
      repeat (2) @(posedge clk);
      #2;
      rd(st_one, {|e, 7'h00});
      rd(st_two, e);
      {fan_slow, diode_two_open_short, diode_one_open_short, overtemp_exceeded} = 7'h00;
      overtemp_below_hyst = 1'b1;
      rd(st_two, e);
      rd(st_two, 8'h00);
    end
    // latch bit survives reads and is dropped only by the latch reset write
    remote_two_limit_event = 1'b1;
    @(posedge clk);
    #2;
    remote_two_limit_event = 1'b0;
    rd2(st_two, 8'h00, 8'h01);
    rd2(st_one, 8'h00, 8'h80);
    wr(lcsf_pkg::ADDR_CONFIG_ONE, 8'h80);
    rd2(st_two, 8'h00, 8'h00);
    shared_pin_mode = 2'h1;
    wr(st_two, 8'h20);
    cmp8("shared_pin_out", 8'h01, {7'h00, shared_pin_out});
    cmp8("shared_pin_oe", 8'h01, {7'h00, shared_pin_oe});
    wr(st_one, 8'hFF);
    rd(st_one, 8'h80);
    wr(st_two, 8'hDF);
    cmp8("shared_pin_out", 8'h00, {7'h00, shared_pin_out});
    shared_pin_mode = 2'h2;
    wr(lcsf_pkg::ADDR_TIMER_LIMIT, 8'h02);
    overtemp_pin_n = 1'b0;
    repeat (8) @(posedge clk);
    #2;
    rd(st_two, 8'h00);
    repeat (20) @(posedge clk);
    #2;
    rd(st_two, 8'h20);
    overtemp_pin_n = 1'b1;
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule : limit_compare_status_flags_tb
`default_nettype wire
